//--- src/freq_level_detect.sv
module freq_level_detect
  import freq_level_pkg::*;
(
  input wire logic clk_i, // system clock, 100 MHz
  input wire logic rst_n_i, // sync reset, active low
  input wire logic [15:0] run_freq_i, // running frequency, 0.01 Hz
  input wire logic [17:0] avs_address_i, // byte address
  input wire logic avs_read_i, // read strobe
  input wire logic avs_write_i, // write strobe
  input wire logic [31:0] avs_writedata_i, // write data
  input wire logic [3:0] avs_byteenable_i, // byte lanes
  output logic [31:0] avs_readdata_o, // read data
  output logic avs_waitrequest_o, // stall
  output logic [1:0] avs_response_o, // 00 ok, 10 slave error
  output logic first_digital_output_o, // output level
  output logic first_digital_output_en_o, // this block drives it
  output logic second_digital_output_o, // output level
  output logic second_digital_output_en_o, // this block drives it
  output logic main_relay_output_o, // output level
  output logic main_relay_output_en_o, // this block drives it
  output logic second_relay_output_o, // output level
  output logic second_relay_output_en_o // this block drives it
);
  import freq_level_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [3:0][15:0] src;
    logic [15:0] level_a;
    logic [15:0] hyst_a;
    logic [15:0] level_b;
    logic [15:0] hyst_b;
    logic [15:0] max_freq;
    logic [15:0] prev_freq;
    logic falling;
    logic ack;
    logic busy;
    logic [31:0] rdata;
    logic [1:0] resp;
    logic [3:0] out;
    logic [3:0] out_en;
  } state_s;

  state_s q;
  state_s next_q;
  logic flag_a;
  logic flag_b;
  logic [15:0] widx;
  logic [15:0] wdata;
  logic hit;
  logic falling_now;
  logic [1:0] rt;

  // merge byte lanes of the low half into a 16-bit value
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                        input logic [3:0] be);
    logic [15:0] r;
    r = old;
    if (be[0]) begin
      r[7:0] = d[7:0];
    end
    if (be[1]) begin
      r[15:8] = d[15:8];
    end
    return r;
  endfunction

  // decode of a selector code; used for all four outputs
  function automatic logic [1:0] route(input logic [15:0] code, input logic fa,
                                       input logic fb);
    logic [1:0] r;
    r = 2'b00; // {enable, level}
    if (code == code_level_a) begin
      r = {1'b1, fa};
    end else if (code == code_level_b) begin
      r = {1'b1, fb};
    end
    return r;
  endfunction

  assign widx = avs_address_i[17:2];

  // direction of the current sample, so a fall into the band is seen at once
  assign falling_now = (run_freq_i < q.prev_freq) ||
    ((run_freq_i == q.prev_freq) && q.falling);

  ////////////////////////////////////////////////////////////////////////
  // two detectors share one comparator design
  level_detector u_det_a (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .freq_i(run_freq_i),
    .falling_i(falling_now),
    .level_i(q.level_a),
    .hyst_i(q.hyst_a),
    .flag_o(flag_a)
  );

  level_detector u_det_b (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .freq_i(run_freq_i),
    .falling_i(falling_now),
    .level_i(q.level_b),
    .hyst_i(q.hyst_b),
    .flag_o(flag_b)
  );

  ////////////////////////////////////////////////////////////////////////
  // bus slave, direction tracking and output routing
  always_comb begin
    next_q = q;
    wdata = 16'h0000;
    hit = 1'b1;
    rt = 2'b00;
    // direction register remembers the last move for a steady frequency
    next_q.prev_freq = run_freq_i;
    next_q.falling = falling_now;
    // one-cycle wait then ack; ack drops for one cycle between requests
    next_q.ack = 1'b0;
    if ((avs_read_i || avs_write_i) && !q.ack) begin
      next_q.ack = 1'b1;
      next_q.rdata = 32'h0000_0000;
      case (widx)
        idx_do1_src: wdata = merge(q.src[0], avs_writedata_i, avs_byteenable_i);
        idx_do2_src: wdata = merge(q.src[1], avs_writedata_i, avs_byteenable_i);
        idx_relay_main_src: wdata = merge(q.src[2], avs_writedata_i, avs_byteenable_i);
        idx_relay_second_src: wdata = merge(q.src[3], avs_writedata_i, avs_byteenable_i);
        idx_level_a_value: wdata = merge(q.level_a, avs_writedata_i, avs_byteenable_i);
        idx_level_a_hyst: wdata = merge(q.hyst_a, avs_writedata_i, avs_byteenable_i);
        idx_level_b_value: wdata = merge(q.level_b, avs_writedata_i, avs_byteenable_i);
        idx_level_b_hyst: wdata = merge(q.hyst_b, avs_writedata_i, avs_byteenable_i);
        idx_max_freq: wdata = merge(q.max_freq, avs_writedata_i, avs_byteenable_i);
        idx_status: wdata = 16'h0000;
        default: hit = 1'b0;
      endcase
      next_q.resp = hit ? 2'b00 : 2'b10;
      if (avs_read_i) begin
        case (widx)
          idx_do1_src: next_q.rdata = {16'h0000, q.src[0]};
          idx_do2_src: next_q.rdata = {16'h0000, q.src[1]};
          idx_relay_main_src: next_q.rdata = {16'h0000, q.src[2]};
          idx_relay_second_src: next_q.rdata = {16'h0000, q.src[3]};
          idx_level_a_value: next_q.rdata = {16'h0000, q.level_a};
          idx_level_a_hyst: next_q.rdata = {16'h0000, q.hyst_a};
          idx_level_b_value: next_q.rdata = {16'h0000, q.level_b};
          idx_level_b_hyst: next_q.rdata = {16'h0000, q.hyst_b};
          idx_max_freq: next_q.rdata = {16'h0000, q.max_freq};
          idx_status: next_q.rdata = {29'h0000_0000, q.falling, flag_b, flag_a};
          default: next_q.rdata = 32'h0000_0000;
        endcase
      end else begin
        // out-of-range values are dropped, register keeps old value
        case (widx)
          idx_do1_src, idx_do2_src, idx_relay_main_src, idx_relay_second_src: begin
            if (wdata <= src_code_max) begin
              next_q.src[widx[1:0]] = wdata;
            end
          end
          idx_level_a_value: begin
            if (wdata <= q.max_freq) begin
              next_q.level_a = wdata;
            end
          end
          idx_level_b_value: begin
            if (wdata <= q.max_freq) begin
              next_q.level_b = wdata;
            end
          end
          idx_level_a_hyst: begin
            if (wdata <= hyst_max) begin
              next_q.hyst_a = wdata;
            end
          end
          idx_level_b_hyst: begin
            if (wdata <= hyst_max) begin
              next_q.hyst_b = wdata;
            end
          end
          idx_max_freq: next_q.max_freq = wdata;
          default: next_q.ack = 1'b1;
        endcase
      end
    end
    // registered stall: high while idle, low only in the cycle after a take
    next_q.busy = !next_q.ack;
    // routing uses registered flags, so outputs lag flags by one cycle
    for (int i = 0; i < 4; i++) begin
      rt = route(q.src[i], flag_a, flag_b);
      next_q.out_en[i] = rt[1];
      next_q.out[i] = rt[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      q <= '0;
      q.src[0] <= rst_do1_src;
      q.src[1] <= rst_do2_src;
      q.src[2] <= rst_relay_main_src;
      q.src[3] <= rst_relay_second_src;
      q.level_a <= rst_level_value;
      q.level_b <= rst_level_value;
      q.hyst_a <= rst_hyst;
      q.hyst_b <= rst_hyst;
      q.max_freq <= rst_max_freq;
      q.busy <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  assign avs_readdata_o = q.rdata;
  assign avs_waitrequest_o = q.busy;
  assign avs_response_o = q.resp;
  assign first_digital_output_o = q.out[0];
  assign first_digital_output_en_o = q.out_en[0];
  assign second_digital_output_o = q.out[1];
  assign second_digital_output_en_o = q.out_en[1];
  assign main_relay_output_o = q.out[2];
  assign main_relay_output_en_o = q.out_en[2];
  assign second_relay_output_o = q.out[3];
  assign second_relay_output_en_o = q.out_en[3];
endmodule

//--- src/freq_level_pkg.sv
package freq_level_pkg;
  // register word indices; byte address is four times the index
  localparam logic [15:0] idx_do1_src = 16'h0A00;
  localparam logic [15:0] idx_do2_src = 16'h0A01;
  localparam logic [15:0] idx_relay_main_src = 16'h0A02;
  localparam logic [15:0] idx_relay_second_src = 16'h0A03;
  localparam logic [15:0] idx_level_a_value = 16'h0A14;
  localparam logic [15:0] idx_level_a_hyst = 16'h0A15;
  localparam logic [15:0] idx_level_b_value = 16'h0A16;
  localparam logic [15:0] idx_level_b_hyst = 16'h0A17;
  localparam logic [15:0] idx_max_freq = 16'h0A40;
  localparam logic [15:0] idx_status = 16'h0A41;
  // reset values
  localparam logic [15:0] rst_do1_src = 16'h0002;
  localparam logic [15:0] rst_do2_src = 16'h0002;
  localparam logic [15:0] rst_relay_main_src = 16'h0008;
  localparam logic [15:0] rst_relay_second_src = 16'h0000;
  localparam logic [15:0] rst_level_value = 16'h01F4;
  localparam logic [15:0] rst_hyst = 16'h0000;
  localparam logic [15:0] rst_max_freq = 16'h1388;
  // ranges and selector codes
  localparam logic [15:0] src_code_max = 16'h0023;
  localparam logic [15:0] hyst_max = 16'h03E8;
  localparam logic [15:0] code_level_a = 16'h000F;
  localparam logic [15:0] code_level_b = 16'h0010;
  // status field positions
  localparam int status_bit_a = 0;
  localparam int status_bit_b = 1;
  localparam int status_bit_falling = 2;
endpackage

//--- src/level_detector.sv
module level_detector
  import freq_level_pkg::*;
(
  input wire logic clk_i, // system clock
  input wire logic rst_n_i, // sync reset, active low
  input wire logic [15:0] freq_i, // running frequency, 0.01 Hz
  input wire logic falling_i, // frequency is decreasing
  input wire logic [15:0] level_i, // detection level, 0.01 Hz
  input wire logic [15:0] hyst_i, // hysteresis, 0.1 %
  output logic flag_o // level-detect flag
);
  import freq_level_pkg::*;

  typedef struct packed {
    logic flag;
  } state_s;

  state_s q;
  state_s next_q;
  logic [31:0] prod;
  logic [15:0] lag;
  logic [15:0] release_lvl;

  // lag = level * pct / 1000, truncated
  assign prod = 32'(level_i) * 32'(hyst_i);
  // full scale of the percentage is 100.0 %, so the quotient never exceeds the level
  assign lag = 16'(prod / {16'h0000, hyst_max});
  assign release_lvl = level_i - lag;

  // set above level; release below level minus lag while falling, below level otherwise
  always_comb begin
    next_q = q;
    if (freq_i > level_i) begin
      next_q.flag = 1'b1;
    end else if (falling_i) begin
      if (freq_i < release_lvl) begin
        next_q.flag = 1'b0;
      end
    end else if (freq_i < level_i) begin
      next_q.flag = 1'b0; // rising: no lag applied
    end
    // while falling, between release and level the flag holds
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign flag_o = q.flag;
endmodule

//--- verification/freq_level_detect_chk.sv
module freq_level_detect_chk (
  input wire logic clk_i, // clock
  input wire logic rst_n_i, // reset
  input wire logic [15:0] run_freq_i, // freq
  input wire logic avs_read_i, // rd
  input wire logic avs_write_i, // wr
  input wire logic [31:0] avs_readdata_o, // data
  input wire logic avs_waitrequest_o, // stall
  input wire logic [1:0] avs_response_o, // resp
  input wire logic first_digital_output_o, // out
  input wire logic first_digital_output_en_o, // en
  input wire logic second_digital_output_o, // out
  input wire logic second_digital_output_en_o, // en
  input wire logic main_relay_output_o, // out
  input wire logic main_relay_output_en_o, // en
  input wire logic second_relay_output_o, // out
  input wire logic second_relay_output_en_o // en
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] outs;
  logic [3:0] ens;
  logic [3:0] quiet;
  logic req;
  assign outs = {first_digital_output_o, second_digital_output_o, main_relay_output_o,
    second_relay_output_o};
  assign ens = {first_digital_output_en_o, second_digital_output_en_o,
    main_relay_output_en_o, second_relay_output_en_o};
  assign req = avs_read_i | avs_write_i;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////////////////////////////////////////////////
  // cycles since the frequency moved or a register was written
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || $changed(run_freq_i) || avs_write_i)
      quiet <= 4'h0;
    else if (quiet != 4'hF)
      quiet <= quiet + 4'h1;
  end
  ////////////////////////////////////////////////////////////////////////////
  a_reset_clear: assert property ($rose(rst_n_i) |-> outs == 4'h0 && ens == 4'h0)
    else $error("outputs not clear after reset");
  a_quiet_hold: assert property (quiet > 4'h6 |-> $stable(outs) && $stable(ens))
    else $error("output moved with steady inputs");
  a_en_by_write: assert property ($changed(ens) |-> $past(avs_write_i))
    else $error("enable moved without a write");
  a_out_enabled: assert property ((outs & ~ens) == 4'h0)
    else $error("output high while not driven");
  a_wait_one: assert property (req && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("stall longer than one cycle");
  a_wait_idle: assert property (!req |=> avs_waitrequest_o)
    else $error("stall low after an idle cycle");
  a_read_high: assert property (avs_read_i && !avs_waitrequest_o |->
    avs_readdata_o[31:16] == 16'h0000) else $error("upper read half not zero");
  a_resp_legal: assert property (req && !avs_waitrequest_o |-> !avs_response_o[0])
    else $error("illegal response code");
  cover property ($rose(first_digital_output_o));
  cover property ($fell(first_digital_output_o));
  cover property (avs_read_i && !avs_waitrequest_o && avs_response_o == 2'b10);
endmodule
bind freq_level_detect freq_level_detect_chk chk_u (.clk_i, .rst_n_i, .run_freq_i,
  .avs_read_i, .avs_write_i, .avs_readdata_o, .avs_waitrequest_o, .avs_response_o,
  .first_digital_output_o, .first_digital_output_en_o, .second_digital_output_o,
  .second_digital_output_en_o, .main_relay_output_o, .main_relay_output_en_o,
  .second_relay_output_o, .second_relay_output_en_o);

//--- verification/freq_source_model.sv
module freq_source_model #(
  parameter logic [15:0] step = 16'h0100 // change per cycle
) (
  input wire logic clk_i, // clock
  input wire logic rst_n_i, // sync reset
  input wire logic [15:0] target_i, // wanted frequency
  output logic [15:0] freq_o // running frequency
);
  timeunit 1ns;
  timeprecision 1ps;
  // ramps like a drive, so intermediate values cross the bands too
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      freq_o <= 16'h0000;
    end else if ({1'b0, freq_o} + step < {1'b0, target_i}) begin
      freq_o <= freq_o + step;
    end else if ({1'b0, target_i} + step < {1'b0, freq_o}) begin
      freq_o <= freq_o - step;
    end else begin
      freq_o <= target_i;
    end
  end
endmodule

//--- verification/freq_level_detect_test.sv
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
  $display("ERROR %s exp %0h got %0h", n, e, g); end end
module freq_level_detect_test;
  timeunit 1ns;
  timeprecision 1ps;
  import freq_level_pkg::*;
  typedef struct packed {logic [15:0] f; logic a; logic b;} row_s;
  logic clk_i = 0, rst_n_i = 0, avs_read_i = 0, avs_write_i = 0, avs_waitrequest_o;
  logic [17:0] avs_address_i = '0;
  logic [31:0] avs_writedata_i = '0, avs_readdata_o, rd;
  logic [3:0] avs_byteenable_i = 4'hF, outs, ens;
  logic [15:0] run_freq_i, target = '0;
  logic [1:0] avs_response_o, rsp;
  int error_cnt = 0, comparisons = 0;
  logic [15:0] ri [8] = '{idx_do1_src, idx_do2_src, idx_relay_main_src, idx_relay_second_src,
    idx_level_a_value, idx_level_a_hyst, idx_level_b_value, idx_level_b_hyst};
  logic [15:0] re [8] = '{rst_do1_src, rst_do2_src, rst_relay_main_src, rst_relay_second_src,
    rst_level_value, rst_hyst, rst_level_value, rst_hyst};
  // level a 10.00 Hz with 10 % lag, level b 20.00 Hz with none
  row_s rows [11] = '{'{16'h01F4, 1'b0, 1'b0}, '{16'h03E9, 1'b1, 1'b0},
    '{16'h03B6, 1'b1, 1'b0}, '{16'h0384, 1'b1, 1'b0}, '{16'h0383, 1'b0, 1'b0},
    '{16'h03B6, 1'b0, 1'b0}, '{16'h03E8, 1'b0, 1'b0}, '{16'h07D1, 1'b1, 1'b1},
    '{16'h07CF, 1'b1, 1'b0}, '{16'h03B6, 1'b1, 1'b0}, '{16'h03D4, 1'b0, 1'b0}};
  ////////////////////////////////////////////////////////////////////////////
  freq_level_detect dut_u (.clk_i, .rst_n_i, .run_freq_i, .avs_address_i, .avs_read_i,
    .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
    .avs_response_o, .first_digital_output_o(outs[3]), .first_digital_output_en_o(ens[3]),
    .second_digital_output_o(outs[2]), .second_digital_output_en_o(ens[2]),
    .main_relay_output_o(outs[1]), .main_relay_output_en_o(ens[1]),
    .second_relay_output_o(outs[0]), .second_relay_output_en_o(ens[0]));
  freq_source_model src_u (.clk_i, .rst_n_i, .target_i(target), .freq_o(run_freq_i));
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  ////////////////////////////////////////////////////////////////////////////
  // one bus cycle; the request stands until stall is seen low at an edge
  task automatic bus(input logic wr, input logic [15:0] idx, input logic [15:0] wd);
    avs_address_i <= {idx, 2'b00};
    avs_writedata_i <= {16'h0000, wd};
    avs_write_i <= wr;
    avs_read_i <= !wr;
    // no cycle count assumed; only the watchdog ends a hung wait
    do begin
      @(posedge clk_i);
    end while (avs_waitrequest_o !== 1'b0);
    rd = avs_readdata_o;
    rsp = avs_response_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd_chk(input logic [15:0] idx, input logic [15:0] e);
    bus(1'b0, idx, 16'h0000);
    `CHK("readback", {16'h0000, e}, rd)
    `CHK("response", 2'b00, rsp)
  endtask
  task automatic settle();
    repeat (16) @(posedge clk_i);
    #1;
  endtask
  task automatic wrap_up();
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // watchdog: whole run needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge clk_i);
    error_cnt++;
    wrap_up();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    `CHK("enables", 4'h0, ens)
    for (int i = 0; i < 8; i++) rd_chk(ri[i], re[i]);
    bus(1'b0, 16'h0A30, 16'h0000);
    `CHK("unmapped", 2'b10, rsp)
    $display("test reset values done");
    bus(1'b1, idx_do1_src, code_level_a);
    bus(1'b1, idx_do2_src, code_level_b);
    bus(1'b1, idx_level_a_value, 16'h03E8);
    bus(1'b1, idx_level_a_hyst, 16'h0064);
    bus(1'b1, idx_level_b_value, 16'h07D0);
    for (int i = 0; i < 11; i++) begin
      target <= rows[i].f;
      settle();
      `CHK("flag a", rows[i].a, outs[3])
      `CHK("flag b", rows[i].b, outs[2])
      @(posedge clk_i);
    end
    $display("test detection rows done");
    bus(1'b1, idx_do1_src, src_code_max + 16'h0001);
    rd_chk(idx_do1_src, code_level_a);
    bus(1'b1, idx_level_a_value, rst_max_freq + 16'h0001);
    rd_chk(idx_level_a_value, 16'h03E8);
    bus(1'b1, idx_level_a_hyst, hyst_max + 16'h0001);
    rd_chk(idx_level_a_hyst, 16'h0064);
    avs_byteenable_i <= 4'h1;
    bus(1'b1, idx_level_b_hyst, 16'h0155);
    avs_byteenable_i <= 4'hF;
    rd_chk(idx_level_b_hyst, 16'h0055);
    $display("test refused writes done");
    target <= 16'h07D1;
    bus(1'b1, idx_relay_main_src, code_level_b);
    bus(1'b1, idx_relay_second_src, code_level_a);
    settle();
    `CHK("relay b", 2'b11, {ens[1], outs[1]})
    `CHK("relay a", 2'b11, {ens[0], outs[0]})
    @(posedge clk_i);
    bus(1'b1, idx_relay_second_src, 16'h0000);
    settle();
    `CHK("relay off", 2'b00, {ens[0], outs[0]})
    @(posedge clk_i);
    rd_chk(idx_status, 16'h0003);
    rd_chk(idx_max_freq, rst_max_freq);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    `CHK("reset outs", 8'h00, {outs, ens})
    $display("test routing and reset done");
    wrap_up();
  end
endmodule
